// file: src/bqp_cfg.svh
`ifndef BQP_CFG_SVH
`define BQP_CFG_SVH

// port width and latch reset value
`define BQP_PORT_W        8
`define BQP_LATCH_RST     8'hff
// bit positions of the timer 2 alternate pins on the pull-up port
`define BQP_T2_COUNT_BIT  0
`define BQP_T2_TRIG_BIT   1
// pin input synchroniser depth
`define BQP_SYNC_DEPTH    3

`endif

// file: src/bqp_pkg.sv
package bqp_pkg;

	// who owns the muxed bus port pins
	typedef enum logic [1:0] {
		BQP_MODE_GPIO   = 2'b00,
		BQP_MODE_EXTBUS = 2'b01,
		BQP_MODE_PROG   = 2'b10,
		BQP_MODE_VERIFY = 2'b11
	} bqp_mode_t;

	// phase of an external bus cycle on the muxed bus port
	typedef enum logic [1:0] {
		BQP_PH_IDLE = 2'b00,
		BQP_PH_ADDR = 2'b01,
		BQP_PH_WDAT = 2'b10,
		BQP_PH_RDAT = 2'b11
	} bqp_phase_t;

endpackage : bqp_pkg

// file: src/bqp_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
`include "bqp_cfg.svh"

// three-stage pin synchroniser; output moves only when stages 2 and 3 agree
module bqp_pin_sync #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// raw pin level and filtered result
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] level
);

	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] next_level;

	// =========================================================
	// agreement filter: s1 is read only by s2
	always_comb begin
		for (int i = 0; i < W; i++) begin
			next_level[i] = (s2[i] == s3[i]) ? s2[i] : level[i];
		end
	end

	// resets to high, matching released or pulled-up pins
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s1    <= {W{1'b1}};
			s2    <= {W{1'b1}};
			s3    <= {W{1'b1}};
			level <= {W{1'b1}};
		end else begin
			s1    <= pin;
			s2    <= s1;
			s3    <= s2;
			level <= next_level;
		end
	end

endmodule : bqp_pin_sync
`default_nettype wire

// file: src/bqp_ports.sv
`timescale 1ns/10ps
`default_nettype none
`include "bqp_cfg.svh"

// =============================================================
// Overview of operation
// - muxed bus port is 8-bit open drain; as general output only drives low
// - latch bit one releases the pin so it can be read as input
// - external memory accesses put address then data on muxed bus pins
// - in bus mode a one is driven high actively, not left floating
// - host gives code bytes in programming; device drives them in verify
// - pull-up port is 8-bit with internal pull-ups; latch one reads input
// - host supplies low address on pull-up port in programming and verify
// - pull-up bit 0 is timer 2 count input or clock output
// - pull-up bit 1 is timer 2 capture, reload and direction trigger
module bqp_ports #(
	parameter int W = `BQP_PORT_W
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              nrst,
	// core latch writes
	input  wire logic              mux_latch_we,
	input  wire logic [W-1:0]      mux_latch_wdata,
	input  wire logic              pu_latch_we,
	input  wire logic [W-1:0]      pu_latch_wdata,
	// pin ownership
	input  wire bqp_pkg::bqp_mode_t mode,
	// external bus phase with address and write data
	input  wire bqp_pkg::bqp_phase_t bus_phase,
	input  wire logic [W-1:0]      bus_addr_lo,
	input  wire logic [W-1:0]      bus_wdata,
	// stored code byte shown in verify mode
	input  wire logic [W-1:0]      verify_code,
	// timer 2 clock-out
	input  wire logic              t2_clkout_en,
	input  wire logic              t2_clkout,
	// muxed bus port pins
	input  wire logic [W-1:0]      muxed_bus_port_in,
	output logic      [W-1:0]      muxed_bus_port_out,
	output logic      [W-1:0]      muxed_bus_port_oe,
	// pull-up port pins
	input  wire logic [W-1:0]      pullup_port_in,
	output logic      [W-1:0]      pullup_port_out,
	output logic      [W-1:0]      pullup_port_oe,
	// values seen by the core
	output logic      [W-1:0]      mux_pin_level,
	output logic      [W-1:0]      pu_pin_level,
	output logic      [W-1:0]      mux_latch,
	output logic      [W-1:0]      pu_latch,
	output logic      [W-1:0]      prog_code,
	output logic      [W-1:0]      prog_addr_lo,
	output logic                   timer2_count_pin,
	output logic                   timer2_trigger_pin
);

	logic [W-1:0] mux_sync;
	logic [W-1:0] pu_sync;
	logic [W-1:0] next_mux_latch;
	logic [W-1:0] next_pu_latch;
	logic [W-1:0] next_mux_out;
	logic [W-1:0] next_mux_oe;
	logic [W-1:0] next_pu_out;
	logic [W-1:0] next_pu_oe;
	logic [W-1:0] next_prog_code;
	logic [W-1:0] next_prog_addr;
	logic [W-1:0] pu_drive;

	// =========================================================
	// pin synchronisers for both ports
	bqp_pin_sync #(.W(W)) u_mux_sync (
		.clk   (clk),
		.nrst  (nrst),
		.pin   (muxed_bus_port_in),
		.level (mux_sync)
	);

	bqp_pin_sync #(.W(W)) u_pu_sync (
		.clk   (clk),
		.nrst  (nrst),
		.pin   (pullup_port_in),
		.level (pu_sync)
	);

	// =========================================================
	// output latches
	always_comb begin
		next_mux_latch = mux_latch_we ? mux_latch_wdata : mux_latch;
		next_pu_latch  = pu_latch_we ? pu_latch_wdata : pu_latch;
	end

	// =========================================================
	// muxed bus port drive
	always_comb begin
		next_mux_out = {W{1'b0}};
		next_mux_oe  = {W{1'b0}};
		case (mode)
			bqp_pkg::BQP_MODE_GPIO: begin
				// open drain: only zeros drive, ones float
				next_mux_out = {W{1'b0}};
				next_mux_oe  = ~mux_latch;
			end
			bqp_pkg::BQP_MODE_EXTBUS: begin
				// both levels driven hard in address and write-data phases; pins released otherwise
				case (bus_phase)
					bqp_pkg::BQP_PH_ADDR: begin
						next_mux_out = bus_addr_lo;
						next_mux_oe  = {W{1'b1}};
					end
					bqp_pkg::BQP_PH_WDAT: begin
						next_mux_out = bus_wdata;
						next_mux_oe  = {W{1'b1}};
					end
					default: begin
						next_mux_out = {W{1'b0}};
						next_mux_oe  = {W{1'b0}};
					end
				endcase
			end
			bqp_pkg::BQP_MODE_PROG: begin
				// host drives code bytes; pins released
				next_mux_out = {W{1'b0}};
				next_mux_oe  = {W{1'b0}};
			end
			bqp_pkg::BQP_MODE_VERIFY: begin
				// stored code byte out; ones need the external pull-up
				next_mux_out = {W{1'b0}};
				next_mux_oe  = ~verify_code;
			end
			default: begin
				next_mux_out = {W{1'b0}};
				next_mux_oe  = {W{1'b0}};
			end
		endcase
	end

	// =========================================================
	// pull-up port drive; a one is modelled as an active high drive
	always_comb begin
		pu_drive = pu_latch;
		if (t2_clkout_en) begin
			pu_drive[`BQP_T2_COUNT_BIT] = t2_clkout;
		end
		next_pu_out = pu_drive;
		next_pu_oe  = {W{1'b1}};
		// host owns the address pins while programming or verifying
		if (mode == bqp_pkg::BQP_MODE_PROG ||
		    mode == bqp_pkg::BQP_MODE_VERIFY) begin
			next_pu_out = {W{1'b0}};
			next_pu_oe  = {W{1'b0}};
		end
	end

	// =========================================================
	// captured host bytes; code byte holds outside programming, address holds outside host modes
	always_comb begin
		next_prog_code = (mode == bqp_pkg::BQP_MODE_PROG) ?
		                 mux_sync : prog_code;
		next_prog_addr = (mode == bqp_pkg::BQP_MODE_PROG ||
		                  mode == bqp_pkg::BQP_MODE_VERIFY) ?
		                 pu_sync : prog_addr_lo;
	end

	// =========================================================
	// all outputs registered; latches reset to ones
	always_ff @(posedge clk) begin
		if (!nrst) begin
			mux_latch          <= W'(`BQP_LATCH_RST);
			pu_latch           <= W'(`BQP_LATCH_RST);
			muxed_bus_port_out <= {W{1'b0}};
			muxed_bus_port_oe  <= {W{1'b0}};
			pullup_port_out    <= {W{1'b0}};
			pullup_port_oe     <= {W{1'b0}};
			mux_pin_level      <= {W{1'b1}};
			pu_pin_level       <= {W{1'b1}};
			prog_code          <= {W{1'b0}};
			prog_addr_lo       <= {W{1'b0}};
			timer2_count_pin   <= 1'b1;
			timer2_trigger_pin <= 1'b1;
		end else begin
			mux_latch          <= next_mux_latch;
			pu_latch           <= next_pu_latch;
			muxed_bus_port_out <= next_mux_out;
			muxed_bus_port_oe  <= next_mux_oe;
			pullup_port_out    <= next_pu_out;
			pullup_port_oe     <= next_pu_oe;
			mux_pin_level      <= mux_sync;
			pu_pin_level       <= pu_sync;
			prog_code          <= next_prog_code;
			prog_addr_lo       <= next_prog_addr;
			timer2_count_pin   <= pu_sync[`BQP_T2_COUNT_BIT];
			timer2_trigger_pin <= pu_sync[`BQP_T2_TRIG_BIT];
		end
	end

	// =========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence gpio_cycle_s;
		mode == bqp_pkg::BQP_MODE_GPIO;
	endsequence

	sequence addr_cycle_s;
		mode == bqp_pkg::BQP_MODE_EXTBUS && bus_phase == bqp_pkg::BQP_PH_ADDR;
	endsequence

	open_drain_a: assert property (gpio_cycle_s |=>
		muxed_bus_port_out == '0 && muxed_bus_port_oe == ~$past(mux_latch))
		else $error("open drain drive wrong");

	release_one_a: assert property (gpio_cycle_s ##0 mux_latch == '1 |=>
		muxed_bus_port_oe == '0)
		else $error("latch one did not release pins");

	addr_phase_a: assert property (addr_cycle_s |=>
		muxed_bus_port_out == $past(bus_addr_lo) && muxed_bus_port_oe == '1)
		else $error("address not on muxed pins");

	strong_high_a: assert property ((mode == bqp_pkg::BQP_MODE_EXTBUS &&
		bus_phase == bqp_pkg::BQP_PH_WDAT) |=> muxed_bus_port_oe == '1)
		else $error("bus write data not driven both ways");

	verify_out_a: assert property (mode == bqp_pkg::BQP_MODE_VERIFY |=>
		muxed_bus_port_oe == ~$past(verify_code))
		else $error("verify code byte not driven");

	pullup_drive_a: assert property ((mode == bqp_pkg::BQP_MODE_GPIO &&
		!t2_clkout_en) |=> pullup_port_out == $past(pu_latch))
		else $error("pull-up port mismatch");

	host_addr_a: assert property (mode == bqp_pkg::BQP_MODE_PROG |=>
		pullup_port_oe == '0 && prog_addr_lo == $past(pu_sync))
		else $error("host address not accepted");

	t2_count_a: assert property (1'b1 |=>
		timer2_count_pin == $past(pu_sync[`BQP_T2_COUNT_BIT]))
		else $error("timer 2 count pin wrong");

	t2_trig_a: assert property (1'b1 |=>
		timer2_trigger_pin == $past(pu_sync[`BQP_T2_TRIG_BIT]))
		else $error("timer 2 trigger pin wrong");

	reset_ones_a: assert property (@(posedge clk) $rose(nrst) |->
		mux_latch == '1 && pu_latch == '1)
		else $error("latches not one after reset");

endmodule : bqp_ports
`default_nettype wire

// file: verification/bqp_pin_env.sv
`timescale 1ns/10ps
`default_nettype none

// ==========
// pin environment: external pull-ups on both ports and a host
module bqp_pin_env (
	// device drivers
	input  wire logic [7:0] mux_out,
	input  wire logic [7:0] mux_oe,
	input  wire logic [7:0] pu_out,
	input  wire logic [7:0] pu_oe,
	// host drivers
	input  wire logic [7:0] host_mux_en,
	input  wire logic [7:0] host_mux_val,
	input  wire logic [7:0] host_pu_en,
	input  wire logic [7:0] host_pu_val,
	// resolved pin levels
	output logic      [7:0] mux_pin,
	output logic      [7:0] pu_pin
);
	// wired-and: any low driver wins, else the pull-up gives one
	// host code byte on the muxed pins, address on the pull-up pins
	assign mux_pin = ~(mux_oe & ~mux_out) &
		~(host_mux_en & ~host_mux_val);
	assign pu_pin  = ~(pu_oe & ~pu_out) &
		~(host_pu_en & ~host_pu_val);
endmodule : bqp_pin_env

`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
	logic                clk, nrst, mwe, pwe, t2en, t2ck;
	logic [7:0]          mwd, pwd, addr, wdat, vcode, hme, hmv, hpe, hpv;
	logic [7:0]          mo, moe, po, poe, mlev, plev, ml, pl, pcode, paddr;
	logic [7:0]          mpin, ppin, d, p;
	logic                cnt_pin, trg_pin;
	bqp_pkg::bqp_mode_t  mode;
	bqp_pkg::bqp_phase_t ph;
	int                  error_cnt, check_count, n;
	integer              seed;

	// ==========
	// device and pin environment
	bqp_ports DUT (.clk(clk), .nrst(nrst), .mux_latch_we(mwe),
		.mux_latch_wdata(mwd), .pu_latch_we(pwe), .pu_latch_wdata(pwd),
		.mode(mode), .bus_phase(ph), .bus_addr_lo(addr), .bus_wdata(wdat),
		.verify_code(vcode), .t2_clkout_en(t2en), .t2_clkout(t2ck),
		.muxed_bus_port_in(mpin), .muxed_bus_port_out(mo),
		.muxed_bus_port_oe(moe), .pullup_port_in(ppin),
		.pullup_port_out(po), .pullup_port_oe(poe), .mux_pin_level(mlev),
		.pu_pin_level(plev), .mux_latch(ml), .pu_latch(pl),
		.prog_code(pcode), .prog_addr_lo(paddr),
		.timer2_count_pin(cnt_pin), .timer2_trigger_pin(trg_pin));
	bqp_pin_env env (.mux_out(mo), .mux_oe(moe), .pu_out(po), .pu_oe(poe),
		.host_mux_en(hme), .host_mux_val(hmv), .host_pu_en(hpe),
		.host_pu_val(hpv), .mux_pin(mpin), .pu_pin(ppin));

	always #5 clk = ~clk;

	// expected wired-and level of a pin pair
	function automatic logic [7:0] wired(input logic [7:0] oe, o, en, v);
		return ~(oe & ~o) & ~(en & ~v);
	endfunction : wired

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wait_n(input int k);
		repeat (k) @(negedge clk);
	endtask : wait_n

	task automatic test_done;
		if (error_cnt == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done

	// watchdog: the run needs about 110 cycles
	initial begin
		#20000;
		error_cnt++;
		test_done();
	end

	// ==========
	// main sequence, inputs move on the falling edge
	initial begin
		seed = 32'h2ba4_90a7;
		{clk, nrst, mwe, pwe, t2en, t2ck} = '0;
		{mwd, pwd, addr, wdat, vcode, hme, hmv, hpe, hpv} = '0;
		mode = bqp_pkg::BQP_MODE_GPIO;
		ph = bqp_pkg::BQP_PH_IDLE;
		wait_n(3);
		nrst = 1'b1;
		wait_n(1);
		chk(ml, 8'hff);
		chk(pl, 8'hff);
		// general port use, all-zero latch as corner case
		for (n = 0; n < 8; n++) begin
			d = (n == 0) ? 8'h00 : 8'($random(seed));
			p = (n == 0) ? 8'h00 : 8'($random(seed));
			{mwe, mwd, pwe, pwd} = {1'b1, d, 1'b1, p};
			wait_n(1);
			{mwe, pwe} = 2'b00;
			wait_n(6);
			chk(moe, ~d);
			chk(mo, 8'h00);
			chk(mlev, wired(~d, 8'h00, 8'h00, 8'h00));
			chk(poe, 8'hff);
			chk(plev, p);
			chk({7'h0, cnt_pin}, {7'h0, p[0]});
			chk({7'h0, trg_pin}, {7'h0, p[1]});
		end
		// host pulls pull-up pins low against latch ones
		{pwe, pwd, hpe, hpv} = {1'b1, 8'hff, 8'($random(seed)), 8'h00};
		wait_n(1);
		pwe = 1'b0;
		wait_n(6);
		chk(plev, ~hpe);
		chk({7'h0, trg_pin}, {7'h0, ~hpe[1]});
		hpe = 8'h00;
		// timer clock-out overrides bit 0
		for (n = 0; n < 2; n++) begin
			{t2en, t2ck} = {1'b1, n[0]};
			wait_n(2);
			chk({7'h0, po[0]}, {7'h0, n[0]});
		end
		t2en = 1'b0;
		// external bus cycles, all-ones address first
		mode = bqp_pkg::BQP_MODE_EXTBUS;
		for (n = 0; n < 4; n++) begin
			addr = (n == 0) ? 8'hff : 8'($random(seed));
			wdat = 8'($random(seed));
			ph = bqp_pkg::BQP_PH_ADDR;
			wait_n(2);
			chk(mo, addr);
			chk(moe, 8'hff);
			ph = bqp_pkg::BQP_PH_WDAT;
			wait_n(2);
			chk(mo, wdat);
			chk(moe, 8'hff);
			ph = bqp_pkg::BQP_PH_RDAT;
			wait_n(2);
			chk(moe, 8'h00);
		end
		ph = bqp_pkg::BQP_PH_IDLE;
		// host programming then verification
		mode = bqp_pkg::BQP_MODE_PROG;
		// random address so the check cannot pass on the reset value
		{hme, hmv} = {8'hff, 8'($random(seed))};
		{hpe, hpv} = {8'hff, 8'($random(seed))};
		wait_n(6);
		chk(pcode, hmv);
		chk(paddr, hpv);
		chk(poe, 8'h00);
		{hme, vcode, hpv} = {8'h00, 8'($random(seed)), 8'($random(seed))};
		mode = bqp_pkg::BQP_MODE_VERIFY;
		wait_n(6);
		chk(moe, ~vcode);
		chk(mo, 8'h00);
		chk(mlev, vcode);
		chk(paddr, hpv);
		// second reset mid-run
		nrst = 1'b0;
		wait_n(2);
		chk(ml, 8'hff);
		chk(moe, 8'h00);
		// release again in general mode: latches of ones leave muxed pins free, pull-up pins driven high
		nrst = 1'b1;
		mode = bqp_pkg::BQP_MODE_GPIO;
		wait_n(1);
		chk(moe, 8'h00);
		chk(poe, 8'hff);
		test_done();
	end
endmodule : testbench

`default_nettype wire
